//--- hdl/timer_set_regs.svh
`ifndef TIMER_SET_REGS_SVH
`define TIMER_SET_REGS_SVH

`define MAIN_WIDTH      16
`define SMALL_WIDTH     8
`define CHAN_COUNT      5
`define PRESCALE_WIDTH  8
`define MAIN_ZERO       16'h0000
`define SMALL_ZERO      8'h00
`define PRESCALE_ZERO   8'h00

`endif

//--- hdl/timer_set_pkg.sv
package timer_set_pkg;

  typedef enum logic [1:0] {
    CH_OFF     = 2'b00,
    CH_PWM     = 2'b01,
    CH_CAPTURE = 2'b11
  } chan_mode_t;

  typedef enum logic [1:0] {
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_BOTH = 2'b11,
    EDGE_NONE = 2'b00
  } edge_sel_t;

  typedef struct packed {
    chan_mode_t  mode;
    edge_sel_t   edge_sel;
    logic [15:0] compare;
  } main_chan_cfg_t;

  typedef struct packed {
    logic        enable;
    logic [7:0]  prescale;
    logic [7:0]  period;
    logic [7:0]  compare;
  } small_cfg_t;

  typedef struct packed {
    logic        enable;
    logic        ir_mode;
    logic [7:0]  prescale;
    logic [15:0] period;
  } main_cfg_t;

endpackage

//--- hdl/small_timer.sv
`timescale 1ns/1ns
`include "timer_set_regs.svh"

module small_timer (
  // Clock and reset.
  input  wire logic                     i_clock,
  input  wire logic                     i_sys_rst,
  // Configuration.
  input  wire timer_set_pkg::small_cfg_t i_cfg,
  // Results.
  output logic [`SMALL_WIDTH-1:0]       o_count,
  output logic                          o_pwm,
  output logic                          o_period_done
);

  logic [`PRESCALE_WIDTH-1:0] pre_q;
  logic [`PRESCALE_WIDTH-1:0] pre_d;
  logic [`SMALL_WIDTH-1:0]    cnt_q;
  logic [`SMALL_WIDTH-1:0]    cnt_d;
  logic                       pwm_q;
  logic                       pwm_d;
  logic                       done_q;
  logic                       done_d;
  logic                       tick;

  always_comb begin
    tick   = i_cfg.enable && (pre_q == i_cfg.prescale);
    pre_d  = i_cfg.enable ? (tick ? `PRESCALE_ZERO : pre_q + 8'h01) : `PRESCALE_ZERO;
    cnt_d  = cnt_q;
    done_d = 1'b0;
    if (!i_cfg.enable) begin
      cnt_d = `SMALL_ZERO;
    end else if (tick) begin
      if (cnt_q >= i_cfg.period) begin
        cnt_d  = `SMALL_ZERO;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 8'h01;
      end
    end
    // Output is high while the count is below the compare value.
    pwm_d = i_cfg.enable && (cnt_d < i_cfg.compare);
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pre_q  <= `PRESCALE_ZERO;
      cnt_q  <= `SMALL_ZERO;
      pwm_q  <= 1'b0;
      done_q <= 1'b0;
    end else begin
      pre_q  <= pre_d;
      cnt_q  <= cnt_d;
      pwm_q  <= pwm_d;
      done_q <= done_d;
    end
  end

  assign o_count       = cnt_q;
  assign o_pwm         = pwm_q;
  assign o_period_done = done_q;

endmodule // small_timer

//--- hdl/timer_set.sv
`timescale 1ns/1ns
`include "timer_set_regs.svh"

module timer_set (
  // Clock and reset.
  input  wire logic                          i_clock,
  input  wire logic                          i_sys_rst,
  // Main timer configuration.
  input  wire timer_set_pkg::main_cfg_t      i_main_cfg,
  input  wire timer_set_pkg::main_chan_cfg_t i_chan_cfg [`CHAN_COUNT],
  // Small timer configuration.
  input  wire timer_set_pkg::small_cfg_t     i_small_a_cfg,
  input  wire timer_set_pkg::small_cfg_t     i_small_b_cfg,
  // Capture inputs from pins.
  input  wire logic [`CHAN_COUNT-1:0]        i_capture_pin,
  // Main timer results.
  output logic [`MAIN_WIDTH-1:0]             o_main_count,
  output logic                               o_main_period_done,
  output logic [`CHAN_COUNT-1:0]             o_chan_out,
  output logic [`MAIN_WIDTH-1:0]             o_capture_value [`CHAN_COUNT],
  output logic [`CHAN_COUNT-1:0]             o_capture_event,
  // Small timer results.
  output logic [`SMALL_WIDTH-1:0]            o_small_a_count,
  output logic                               o_small_a_pwm,
  output logic                               o_small_a_period_done,
  output logic [`SMALL_WIDTH-1:0]            o_small_b_count,
  output logic                               o_small_b_pwm,
  output logic                               o_small_b_period_done
);

  ////////////////////////////////////////////////////////////////////////////////
  // Small timers.

  // Timer A is tapped inside the block because IR mode paces and gates the main
  // timer with it; timer B only ever drives its own pins.
  logic small_a_pwm;
  logic small_a_done;

  small_timer u_small_a (
    .i_clock       (i_clock),
    .i_sys_rst     (i_sys_rst),
    .i_cfg         (i_small_a_cfg),
    .o_count       (o_small_a_count),
    .o_pwm         (small_a_pwm),
    .o_period_done (small_a_done)
  );

  small_timer u_small_b (
    .i_clock       (i_clock),
    .i_sys_rst     (i_sys_rst),
    .i_cfg         (i_small_b_cfg),
    .o_count       (o_small_b_count),
    .o_pwm         (o_small_b_pwm),
    .o_period_done (o_small_b_period_done)
  );

  assign o_small_a_pwm         = small_a_pwm;
  assign o_small_a_period_done = small_a_done;

  ////////////////////////////////////////////////////////////////////////////////
  // Main counter.

  logic [`PRESCALE_WIDTH-1:0] pre_q;
  logic [`PRESCALE_WIDTH-1:0] pre_d;
  logic [`MAIN_WIDTH-1:0]     cnt_q;
  logic [`MAIN_WIDTH-1:0]     cnt_d;
  logic                       done_q;
  logic                       done_d;
  logic                       pre_tick;
  logic                       tick;

  // The prescaler keeps running in IR mode although its tick is unused there, so
  // leaving IR mode resumes at whatever prescale phase it has reached, not at zero.
  // Dropping enable is the way to restart a timer from a known phase.
  // A period of zero makes the counter wrap on every tick.
  always_comb begin
    pre_tick = i_main_cfg.enable && (pre_q == i_main_cfg.prescale);
    pre_d    = (i_main_cfg.enable && !pre_tick) ? pre_q + 8'h01 : `PRESCALE_ZERO;
    // IR mode swaps the tick source for the first small timer's period pulse.
    tick     = i_main_cfg.ir_mode ? (i_main_cfg.enable && small_a_done) : pre_tick;
    cnt_d    = cnt_q;
    done_d   = 1'b0;
    if (!i_main_cfg.enable) begin
      cnt_d = `MAIN_ZERO;
    end else if (tick) begin
      if (cnt_q >= i_main_cfg.period) begin
        cnt_d  = `MAIN_ZERO;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pre_q  <= `PRESCALE_ZERO;
      cnt_q  <= `MAIN_ZERO;
      done_q <= 1'b0;
    end else begin
      pre_q  <= pre_d;
      cnt_q  <= cnt_d;
      done_q <= done_d;
    end
  end

  assign o_main_count       = cnt_q;
  assign o_main_period_done = done_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Capture pin synchronisers: three stages, a change counts when stages two and
  // three agree, so stage one is read only by stage two.

  logic [`CHAN_COUNT-1:0] sync1_q;
  logic [`CHAN_COUNT-1:0] sync2_q;
  logic [`CHAN_COUNT-1:0] sync3_q;
  logic [`CHAN_COUNT-1:0] level_q;
  logic [`CHAN_COUNT-1:0] level_d;

  always_comb begin
    level_d = level_q;
    for (int i = 0; i < `CHAN_COUNT; i++) begin
      if (sync2_q[i] == sync3_q[i]) begin
        level_d[i] = sync3_q[i];
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      level_q <= '0;
    end else begin
      sync1_q <= i_capture_pin;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      level_q <= level_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Channels.

  logic [`CHAN_COUNT-1:0] out_q;
  logic [`CHAN_COUNT-1:0] out_d;
  logic [`CHAN_COUNT-1:0] cap_evt_q;
  logic [`CHAN_COUNT-1:0] cap_evt_d;
  logic [`MAIN_WIDTH-1:0] cap_val_q [`CHAN_COUNT];
  logic [`MAIN_WIDTH-1:0] cap_val_d [`CHAN_COUNT];

  // PWM outputs compare the next count, so each registered output lines up with the
  // count shown in the same cycle.
  // In IR mode the carrier is timer A's registered output, so the gated signal lags
  // timer A's own pin by one clock; the trade keeps every channel output a flip-flop.
  // A capture stores the count shown in the cycle before its event pulse, and it
  // still works with the main timer disabled, when it records zero.
  always_comb begin
    logic rise;
    logic fall;
    logic hit;
    rise = 1'b0;
    fall = 1'b0;
    hit  = 1'b0;
    for (int i = 0; i < `CHAN_COUNT; i++) begin
      rise         = level_d[i] && !level_q[i];
      fall         = !level_d[i] && level_q[i];
      hit          = (rise && i_chan_cfg[i].edge_sel[0]) || (fall && i_chan_cfg[i].edge_sel[1]);
      cap_val_d[i] = cap_val_q[i];
      cap_evt_d[i] = 1'b0;
      out_d[i]     = 1'b0;
      unique case (i_chan_cfg[i].mode)
        timer_set_pkg::CH_PWM: begin
          out_d[i] = i_main_cfg.enable && (cnt_d < i_chan_cfg[i].compare);
          if (i_main_cfg.ir_mode) begin
            out_d[i] = out_d[i] && small_a_pwm;
          end
        end
        timer_set_pkg::CH_CAPTURE: begin
          if (hit) begin
            cap_val_d[i] = cnt_q;
            cap_evt_d[i] = 1'b1;
          end
        end
        default: begin
          out_d[i] = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      out_q     <= '0;
      cap_evt_q <= '0;
      for (int i = 0; i < `CHAN_COUNT; i++) begin
        cap_val_q[i] <= `MAIN_ZERO;
      end
    end else begin
      out_q     <= out_d;
      cap_evt_q <= cap_evt_d;
      for (int i = 0; i < `CHAN_COUNT; i++) begin
        cap_val_q[i] <= cap_val_d[i];
      end
    end
  end

  assign o_chan_out      = out_q;
  assign o_capture_event = cap_evt_q;
  assign o_capture_value = cap_val_q;

endmodule // timer_set

//--- testbench/timer_set_sva.sv
`timescale 1ns/1ns
module timer_set_sva (
  // Clock and reset.
  input wire logic                          i_clock,
  input wire logic                          i_sys_rst,
  // Configuration.
  input wire timer_set_pkg::main_cfg_t      i_main_cfg,
  input wire timer_set_pkg::main_chan_cfg_t i_chan_cfg [5],
  input wire timer_set_pkg::small_cfg_t     i_small_a_cfg,
  // Results.
  input wire logic [15:0]                   o_main_count,
  input wire logic                          o_main_period_done,
  input wire logic [4:0]                    o_chan_out,
  input wire logic [15:0]                   o_capture_value [5],
  input wire logic [4:0]                    o_capture_event,
  input wire logic [7:0]                    o_small_a_count,
  input wire logic                          o_small_a_pwm,
  input wire logic                          o_small_a_period_done
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  // Outputs lag reset and config changes, so the main done, PWM and IR checks judge only settled stretches.
  sequence s_main_steady;
    !$past(i_sys_rst) && !$past(i_sys_rst, 2) && i_main_cfg.enable
    ##0 $stable(i_main_cfg) && i_main_cfg == $past(i_main_cfg, 2);
  endsequence
  sequence s_a_steady;
    !$past(i_sys_rst) && !$past(i_sys_rst, 2) && i_small_a_cfg.enable
    ##0 $stable(i_small_a_cfg) && i_small_a_cfg == $past(i_small_a_cfg, 2);
  endsequence
  a_small_wrap: assert property (o_small_a_period_done |-> o_small_a_count == 8'h00)
    else $error("small done without zero");
  a_main_done: assert property (s_main_steady ##0 o_main_period_done |->
    $past(o_main_count) >= i_main_cfg.period && o_main_count == 16'h0000)
    else $error("main done off period");
  a_small_pwm: assert property (s_a_steady |->
    o_small_a_pwm == (o_small_a_count < i_small_a_cfg.compare)) else $error("small pwm wrong");
  a_main_pwm: assert property (s_main_steady ##0 (!i_main_cfg.ir_mode &&
    i_chan_cfg[0].mode == timer_set_pkg::CH_PWM && $stable(i_chan_cfg[0]))
    |-> o_chan_out[0] == (o_main_count < i_chan_cfg[0].compare)) else $error("main pwm wrong");
  a_ir_gate: assert property (s_main_steady ##0 (i_main_cfg.ir_mode && o_chan_out[0])
    |-> $past(o_small_a_pwm)) else $error("ir output not gated");
  a_ir_tick: assert property (s_main_steady ##0 (i_main_cfg.ir_mode &&
    $changed(o_main_count)) |-> $past(o_small_a_period_done) || o_small_a_period_done)
    else $error("ir count moved without period");
  a_cap_value: assert property (o_capture_event[1] |->
    o_capture_value[1] == $past(o_main_count)) else $error("capture value wrong");
  a_off_quiet: assert property (i_chan_cfg[2].mode == timer_set_pkg::CH_OFF &&
    $stable(i_chan_cfg[2]) |-> !o_chan_out[2] && !o_capture_event[2])
    else $error("off channel active");
endmodule // timer_set_sva

bind timer_set timer_set_sva i_timer_set_sva (
  .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_main_cfg(i_main_cfg),
  .i_chan_cfg(i_chan_cfg), .i_small_a_cfg(i_small_a_cfg), .o_main_count(o_main_count),
  .o_main_period_done(o_main_period_done), .o_chan_out(o_chan_out),
  .o_capture_value(o_capture_value), .o_capture_event(o_capture_event),
  .o_small_a_count(o_small_a_count), .o_small_a_pwm(o_small_a_pwm),
  .o_small_a_period_done(o_small_a_period_done));

//--- testbench/pin_source.sv
`timescale 1ns/1ns
module pin_source (
  // Clock and requested pin levels.
  input  wire logic       i_clock,
  input  wire logic [4:0] i_level,
  // Pins.
  output logic      [4:0] o_pin
);
  // Pins move 3 ns after the edge, as an outside source unrelated to the clock would.
  initial o_pin = 5'h00;
  always @(posedge i_clock) o_pin <= #3 i_level;
endmodule // pin_source

//--- testbench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic                          i_clock = 1'b0;
  logic                          i_sys_rst = 1'b1;
  timer_set_pkg::main_cfg_t      mcfg = '0;
  timer_set_pkg::main_chan_cfg_t ccfg [5];
  timer_set_pkg::small_cfg_t     acfg = '0;
  timer_set_pkg::small_cfg_t     bcfg = '0;
  logic [4:0]                    lvl = 5'h00;
  logic [4:0]                    pins, cout, cev;
  logic [15:0]                   mcnt;
  logic [15:0]                   cval [5];
  logic [7:0]                    acnt, bcnt;
  logic                          mdn, apwm, adn, bpwm, bdn;
  int                            n_fail = 0;
  int                            compares = 0;

  always #5 i_clock = ~i_clock;

  pin_source i_pin_source (.i_clock(i_clock), .i_level(lvl), .o_pin(pins));
  timer_set i_timer_set (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_main_cfg(mcfg), .i_chan_cfg(ccfg),
    .i_small_a_cfg(acfg), .i_small_b_cfg(bcfg), .i_capture_pin(pins),
    .o_main_count(mcnt), .o_main_period_done(mdn), .o_chan_out(cout),
    .o_capture_value(cval), .o_capture_event(cev), .o_small_a_count(acnt),
    .o_small_a_pwm(apwm), .o_small_a_period_done(adn), .o_small_b_count(bcnt),
    .o_small_b_pwm(bpwm), .o_small_b_period_done(bdn));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] got, exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  function automatic logic [15:0] cnt(input int s);
    return s == 0 ? {8'h00, acnt} : s == 1 ? {8'h00, bcnt} : mcnt;
  endfunction

  function automatic logic dn(input int s);
    return s == 0 ? adn : s == 1 ? bdn : mdn;
  endfunction

  task automatic step;
    @(posedge i_clock);
    #1;
  endtask

  task automatic wait_done(input int s);
    for (int i = 0; i < 3000; i++) begin
      step();
      if (dn(s) === 1'b1) return;
    end
    n_fail++;
    test_done();
  endtask

  // Reference model starts right after a wrap, when count and prescaler are both zero.
  task automatic run_timer(input int s, input logic [15:0] ps, per, cmp);
    logic [15:0] c, p;
    logic        tk, wr;
    wait_done(s);
    c = 16'h0000;
    p = 16'h0000;
    repeat (3 * (per + 1) * (ps + 1)) begin
      step();
      tk = p == ps;
      p = tk ? 16'h0000 : p + 16'h0001;
      wr = tk && c >= per;
      if (tk) c = wr ? 16'h0000 : c + 16'h0001;
      check(cnt(s), c);
      check(dn(s), wr);
      if (s == 2) begin
        for (int k = 0; k < 5; k++) check(cout[k], c < ccfg[k].compare);
      end else begin
        check(s ? bpwm : apwm, c < cmp);
      end
    end
    $display("timer %0d checked", s);
  endtask

  task automatic test_main;
    logic [15:0] cmp [5] = '{16'h0003, 16'h0000, 16'h0009, 16'h000a, 16'h0020};
    @(posedge i_clock);
    mcfg <= '{1'b1, 1'b0, 8'h02, 16'h0009};
    for (int k = 0; k < 5; k++) begin
      ccfg[k] <= '{timer_set_pkg::CH_PWM, timer_set_pkg::EDGE_NONE, cmp[k]};
    end
    run_timer(2, 16'h0002, 16'h0009, 16'h0000);
  endtask

  task automatic test_ir;
    logic [15:0] pm;
    logic        pa;
    int          nd, nc;
    @(posedge i_clock);
    acfg <= '{1'b1, 8'h00, 8'h03, 8'h02};
    mcfg <= '{1'b1, 1'b1, 8'h00, 16'h0003};
    repeat (3) wait_done(0);
    nd = 0;
    nc = 0;
    pa = apwm;
    pm = mcnt;
    repeat (60) begin
      step();
      if (mcnt !== pm) nc++;
      if (adn === 1'b1) nd++;
      check(cout[0], mcnt < ccfg[0].compare && pa);
      pa = apwm;
      pm = mcnt;
    end
    check(nc, nd);
    $display("ir mode checked");
  endtask

  task automatic cap_watch(input logic [4:0] l, input logic [15:0] want);
    logic [15:0] pm;
    int          n;
    n = 0;
    @(posedge i_clock);
    lvl <= l;
    #1;
    pm = mcnt;
    repeat (12) begin
      step();
      if (cev[1] === 1'b1) n++;
      if (cev[1] === 1'b1) check(cval[1], pm);
      check(cev[2], 1'b0);
      pm = mcnt;
    end
    check(n, want);
    $display("capture checked");
  endtask

  // Timer B's compare sits inside its period so that its output really toggles.
  task automatic test_small;
    @(posedge i_clock);
    acfg <= '{1'b1, 8'h01, 8'h02, 8'h01};
    bcfg <= '{1'b1, 8'h00, 8'h03, 8'h02};
    run_timer(0, 16'h0001, 16'h0002, 16'h0001);
    run_timer(1, 16'h0000, 16'h0003, 16'h0002);
  endtask

  // Rising capture first, then the same channel switched to falling edges only.
  task automatic test_capture;
    @(posedge i_clock);
    mcfg <= '{1'b1, 1'b0, 8'h00, 16'h00ff};
    ccfg[1] <= '{timer_set_pkg::CH_CAPTURE, timer_set_pkg::EDGE_RISE, 16'h0000};
    ccfg[2] <= '{timer_set_pkg::CH_OFF, timer_set_pkg::EDGE_BOTH, 16'h0000};
    cap_watch(5'h06, 16'h0001);
    cap_watch(5'h00, 16'h0000);
    @(posedge i_clock);
    ccfg[1] <= '{timer_set_pkg::CH_CAPTURE, timer_set_pkg::EDGE_FALL, 16'h0000};
    cap_watch(5'h06, 16'h0000);
    cap_watch(5'h00, 16'h0001);
  endtask

  initial begin
    for (int k = 0; k < 5; k++) ccfg[k] = '0;
    repeat (6) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    test_small();
    test_main();
    test_ir();
    test_capture();
    test_done();
  end
endmodule // tb_top
